// file: src/tps_cfg.svh
`ifndef TPS_CFG_SVH
`define TPS_CFG_SVH

// ==========================================================
// Configuration register offsets
`define TPS_REG_PIXEL      7'h00
`define TPS_REG_FILL       7'h01
`define TPS_REG_SELECT     7'h03
`define TPS_REG_ADDR_HI    7'h04
`define TPS_REG_ADDR_LO    7'h05
`define TPS_REG_DATA       7'h06
`define TPS_REG_CMD        7'h07
`define TPS_REG_FEED_HI    7'h48
`define TPS_REG_FEED_LO    7'h49
`define TPS_REG_COUNT_HI   7'h4A
`define TPS_REG_COUNT_LO   7'h4B

// ==========================================================
// Field positions and limits
`define TPS_DIR_BIT        6
`define TPS_GAMMA_LAST     14'h0FFD
`define TPS_COEF_LAST      14'h3FFF
`define TPS_GAMMA_HI_MASK  8'h0F

// ==========================================================
// Command codes
`define TPS_CMD_IDLE       8'h00
`define TPS_CMD_FWD        8'h01
`define TPS_CMD_REV        8'h02
`define TPS_CMD_PFWD       8'h05
`define TPS_CMD_PREV       8'h06
`define TPS_CMD_SCAN       8'h08

// ==========================================================
// Reset values and timing
`define TPS_FEED_RESET     16'h0010
`define TPS_COUNT_RESET    16'h0000
`define TPS_SYS_CLK_NS     40
`define TPS_HOLD_TICK_NS   1000000

`endif

// file: src/tps_pkg.sv
// ==========================================================
// Shared types
package tps_pkg;

  // Motion and scan sequencer
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_PRE   = 3'b001,
    ST_SCAN  = 3'b010,
    ST_FEED  = 3'b011,
    ST_TRAIL = 3'b100
  } tps_state_e;

  // Table target field
  typedef enum logic [1:0] {
    TGT_OFFSET = 2'b00,
    TGT_GAIN   = 2'b01,
    TGT_GAMMA  = 2'b10,
    TGT_UNDEF  = 2'b11
  } tps_target_e;

  // Colour plane field
  typedef enum logic [1:0] {
    COL_RED   = 2'b00,
    COL_GREEN = 2'b01,
    COL_BLUE  = 2'b10,
    COL_UNDEF = 2'b11
  } tps_color_e;

endpackage

// file: src/tps_tick.sv
`timescale 1ns/100ps

// ==========================================================
// Programmable enable pulse divider
module tps_tick (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst,
  // Control
  input  wire logic        run,
  input  wire logic [15:0] period,
  // Enable pulse
  output logic             tick
);

  logic [15:0] cnt_ff;   // Cycles since last pulse
  logic [15:0] nxt_cnt;
  logic        tick_ff;  // Registered pulse
  logic        nxt_tick;

  // Next count, a period of zero acts as one
  always_comb begin
    nxt_cnt  = cnt_ff;
    nxt_tick = 1'b0;
    if (!run) begin
      nxt_cnt = 16'h0000;
    end else if (({1'b0, cnt_ff} + 17'h00001) >= {1'b0, period}) begin
      nxt_cnt  = 16'h0000;
      nxt_tick = 1'b1;
    end else begin
      nxt_cnt = cnt_ff + 16'h0001;
    end
  end

  // Registers
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cnt_ff  <= 16'h0000;
      tick_ff <= 1'b0;
    end else begin
      cnt_ff  <= nxt_cnt;
      tick_ff <= nxt_tick;
    end
  end

  assign tick = tick_ff;

endmodule

// file: src/tps_top.sv
`timescale 1ns/100ps
`include "tps_cfg.svh"

// Notes on behaviour
// - Select bits 1:0 pick offset, gain, gamma
// - Select bits 3:2 pick red, green, blue
// - Fourteen bit table address over two registers
// - Direction bit set means reads, prefetch data
// - Address advances after every two byte word
// - Gamma address wraps after 4093
// - Gain and offset address wraps after 16383
// - Table bytes move through data register 06
// - High byte first, gamma top nibble zero
// - Scan first advances programmed full steps
// - Scan ends on new command or sensor
// - Line buffer cleared when scanning starts
// - Pixels at 00, other registers stay live
// - Full buffer pauses, hold timeout drops power
// - Line ends with status word of fill
// - Eight bit line length formula
// - Sixteen bit mode emits two bytes per pixel
// - Fast forward, extra steps after sensor two
// - Fast reverse, sensor stops with no extras
// - Programmed feeds stop after line count
module tps_top #(
  parameter int HOLD_TICK_CYC = `TPS_HOLD_TICK_NS / `TPS_SYS_CLK_NS
) (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst,
  // Configuration register port
  input  wire logic [6:0]  cfg_addr,
  input  wire logic        cfg_wr,
  input  wire logic        cfg_rd,
  input  wire logic [7:0]  cfg_wdata,
  output logic [7:0]       cfg_rdata,
  output logic             cfg_rvalid,
  // Table memory port
  output logic             tbl_req,
  output logic             tbl_we,
  output logic [1:0]       tbl_target,
  output logic [1:0]       tbl_color,
  output logic [13:0]      tbl_addr,
  output logic [15:0]      tbl_wdata,
  input  wire logic        tbl_ack,
  input  wire logic [15:0] tbl_rdata,
  // Image buffer
  output logic             buf_rd,
  input  wire logic [7:0]  buf_rdata,
  input  wire logic [7:0]  buf_fill,
  input  wire logic        buf_full,
  output logic             buf_clear,
  // Pixel stream into buffer
  input  wire logic        mode16,
  input  wire logic        pix_valid,
  input  wire logic [15:0] pix_data,
  input  wire logic        line_end,
  output logic             out_valid,
  output logic [7:0]       out_byte,
  // Line length
  input  wire logic [13:0] data_pixels,
  input  wire logic [3:0]  hdpi_div,
  input  wire logic        color_pixel_rate,
  input  wire logic [1:0]  bits_code,
  output logic [19:0]      bytes_per_line,
  // Motion
  input  wire logic [15:0] scan_stepsize,
  input  wire logic        sense1_trip,
  input  wire logic        sense2_trip,
  input  wire logic [7:0]  extra_steps,
  input  wire logic [7:0]  hold_timeout,
  output logic             step_pulse,
  output logic             step_fwd,
  output logic             motor_power,
  output logic             scanning
);

  // ==========================================================
  // Register group
  logic [3:0]  sel_ff,   nxt_sel;      // Target and colour
  logic        dir_ff,   nxt_dir;      // Read direction
  logic [13:0] addr_ff,  nxt_addr;     // Table word address
  logic [7:0]  cmd_ff,   nxt_cmd;      // Command register
  logic [15:0] feed_ff,  nxt_feed;     // Fast feed step size
  logic [15:0] lines_ff, nxt_lines;    // Step or line count
  logic [7:0]  hib_ff,   nxt_hib;      // Written high byte
  logic        ph_ff,    nxt_ph;       // Low byte next
  logic [15:0] word_ff,  nxt_word;     // Prefetched word
  logic        req_ff,   nxt_req;      // Memory request open
  logic        we_ff,    nxt_we;       // Request is a write
  logic [15:0] wd_ff,    nxt_wd;       // Write word
  logic [7:0]  rdat_ff,  nxt_rdat;     // Read answer
  logic        rv_ff,    nxt_rv;       // Read answer valid
  logic        brd_ff,   nxt_brd;      // Pixel byte pop
  logic        gam_hi_ff, nxt_gam_hi;  // Last read was gamma high
  logic        is_gamma;               // Gamma target selected
  logic [13:0] last_addr;              // Wrap point
  logic        data_acc;               // Data register access
  logic        word_done;              // Second byte completed
  logic        hw_stop;                // Motion ended by hardware

  assign is_gamma  = (sel_ff[1:0] == tps_pkg::TGT_GAMMA);
  assign last_addr = is_gamma ? `TPS_GAMMA_LAST : `TPS_COEF_LAST;
  assign data_acc  = (cfg_wr || cfg_rd) && (cfg_addr == `TPS_REG_DATA) && !req_ff;
  assign word_done = data_acc && ph_ff;

  // Register writes, table port and read answers
  always_comb begin
    nxt_sel = sel_ff;  nxt_dir = dir_ff;  nxt_addr = addr_ff;
    nxt_cmd = cmd_ff;  nxt_feed = feed_ff; nxt_lines = lines_ff;
    nxt_hib = hib_ff;  nxt_ph = ph_ff;    nxt_word = word_ff;
    nxt_req = req_ff;  nxt_we = we_ff;    nxt_wd = wd_ff;
    nxt_rdat = rdat_ff; nxt_rv = cfg_rd;  nxt_brd = 1'b0;
    nxt_gam_hi = 1'b0;
    // Memory handshake closes the request
    if (req_ff && tbl_ack) begin
      nxt_req = 1'b0;
      if (!we_ff) begin
        nxt_word = tbl_rdata;
      end
    end
    // Hardware stop returns command to idle
    if (hw_stop) begin
      nxt_cmd = `TPS_CMD_IDLE;
    end
    if (cfg_wr) begin
      unique case (cfg_addr)
        `TPS_REG_SELECT: nxt_sel = cfg_wdata[3:0];
        `TPS_REG_ADDR_HI: begin
          nxt_addr[13:8] = cfg_wdata[5:0];
          nxt_dir        = cfg_wdata[`TPS_DIR_BIT];
          nxt_ph         = 1'b0;
        end
        `TPS_REG_ADDR_LO: begin
          nxt_addr[7:0] = cfg_wdata;
          nxt_ph        = 1'b0;
          if (dir_ff) begin
            nxt_req = 1'b1;
            nxt_we  = 1'b0;
          end
        end
        `TPS_REG_CMD:      nxt_cmd = cfg_wdata;
        `TPS_REG_FEED_HI:  nxt_feed[15:8] = cfg_wdata;
        `TPS_REG_FEED_LO:  nxt_feed[7:0] = cfg_wdata;
        `TPS_REG_COUNT_HI: nxt_lines[15:8] = cfg_wdata;
        `TPS_REG_COUNT_LO: nxt_lines[7:0] = cfg_wdata;
        default: ;
      endcase
    end
    if (data_acc) begin
      nxt_ph = !ph_ff;
      if (cfg_wr && !ph_ff) begin
        nxt_hib = is_gamma ? (cfg_wdata & `TPS_GAMMA_HI_MASK) : cfg_wdata;
      end
      if (cfg_wr && ph_ff) begin
        nxt_req = 1'b1;
        nxt_we  = 1'b1;
        nxt_wd  = {hib_ff, cfg_wdata};
      end
      if (cfg_rd && ph_ff) begin
        nxt_req = 1'b1;
        nxt_we  = 1'b0;
      end
    end
    if (word_done) begin
      nxt_addr = (addr_ff == last_addr) ? 14'h0000 : (addr_ff + 14'h0001);
    end
    // read answers, pixel pop at 00
    if (cfg_rd) begin
      unique case (cfg_addr)
        `TPS_REG_PIXEL: begin
          nxt_rdat = buf_rdata;
          nxt_brd  = 1'b1;
        end
        `TPS_REG_FILL:     nxt_rdat = buf_fill;
        `TPS_REG_SELECT:   nxt_rdat = {4'h0, sel_ff};
        `TPS_REG_ADDR_HI:  nxt_rdat = {1'b0, dir_ff, addr_ff[13:8]};
        `TPS_REG_ADDR_LO:  nxt_rdat = addr_ff[7:0];
        // gamma high byte reads upper nibble as zero
        `TPS_REG_DATA: begin
          if (req_ff) begin
            nxt_rdat = 8'h00;
          end else if (!ph_ff) begin
            nxt_rdat   = is_gamma ? (word_ff[15:8] & `TPS_GAMMA_HI_MASK) : word_ff[15:8];
            nxt_gam_hi = is_gamma;
          end else begin
            nxt_rdat = word_ff[7:0];
          end
        end
        `TPS_REG_CMD:      nxt_rdat = cmd_ff;
        `TPS_REG_FEED_HI:  nxt_rdat = feed_ff[15:8];
        `TPS_REG_FEED_LO:  nxt_rdat = feed_ff[7:0];
        `TPS_REG_COUNT_HI: nxt_rdat = lines_ff[15:8];
        `TPS_REG_COUNT_LO: nxt_rdat = lines_ff[7:0];
        default:           nxt_rdat = 8'h00;
      endcase
    end
  end

  // Register group flops
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sel_ff <= 4'h0;  dir_ff <= 1'b0;  addr_ff <= 14'h0000;
      cmd_ff <= `TPS_CMD_IDLE;  feed_ff <= `TPS_FEED_RESET;  lines_ff <= `TPS_COUNT_RESET;
      hib_ff <= 8'h00; ph_ff <= 1'b0;   word_ff <= 16'h0000;
      req_ff <= 1'b0;  we_ff <= 1'b0;   wd_ff <= 16'h0000;
      rdat_ff <= 8'h00; rv_ff <= 1'b0;  brd_ff <= 1'b0;  gam_hi_ff <= 1'b0;
    end else begin
      sel_ff <= nxt_sel;   dir_ff <= nxt_dir;   addr_ff <= nxt_addr;
      cmd_ff <= nxt_cmd;   feed_ff <= nxt_feed; lines_ff <= nxt_lines;
      hib_ff <= nxt_hib;   ph_ff <= nxt_ph;     word_ff <= nxt_word;
      req_ff <= nxt_req;   we_ff <= nxt_we;     wd_ff <= nxt_wd;
      rdat_ff <= nxt_rdat; rv_ff <= nxt_rv;     brd_ff <= nxt_brd;
      gam_hi_ff <= nxt_gam_hi;
    end
  end

  assign cfg_rdata  = rdat_ff;
  assign cfg_rvalid = rv_ff;
  assign tbl_req    = req_ff;
  assign tbl_we     = we_ff;
  assign tbl_target = sel_ff[1:0];
  assign tbl_color  = sel_ff[3:2];
  assign tbl_addr   = addr_ff;
  assign tbl_wdata  = wd_ff;
  assign buf_rd     = brd_ff;

  // ==========================================================
  // Motion and scan sequencer
  tps_pkg::tps_state_e st_ff, nxt_st;  // Sequencer state
  logic        fwd_ff,  nxt_fwd;       // Motor direction
  logic        prog_ff, nxt_prog;      // Counted feed
  logic [15:0] cnt_ff,  nxt_cnt;       // Remaining steps
  logic        clr_ff,  nxt_clr;       // Buffer clear pulse
  logic        stp_ff,  nxt_stp;       // Step pulse
  logic [7:0]  hold_ff, nxt_hold;      // Milliseconds paused
  logic        pwr_ff,  nxt_pwr;       // Motor power
  logic        step_tick;              // Step rate enable
  logic        ms_tick;                // Hold timer enable
  logic        cmd_wr;                 // Command write now
  logic        paused;                 // Scan held by full buffer

  assign cmd_wr = cfg_wr && (cfg_addr == `TPS_REG_CMD);
  assign paused = (st_ff == tps_pkg::ST_SCAN) && buf_full;

  // Step rate divider
  tps_tick u_step (
    .sys_clk (sys_clk),
    .rst     (rst),
    .run     (st_ff != tps_pkg::ST_IDLE),
    .period  ((st_ff == tps_pkg::ST_SCAN) ? scan_stepsize : feed_ff),
    .tick    (step_tick)
  );

  // Hold timeout base
  tps_tick u_hold (
    .sys_clk (sys_clk),
    .rst     (rst),
    .run     (paused),
    .period  (16'(HOLD_TICK_CYC)),
    .tick    (ms_tick)
  );

  // Next sequencer state
  always_comb begin
    nxt_st = st_ff;  nxt_fwd = fwd_ff;  nxt_prog = prog_ff;
    nxt_cnt = cnt_ff; nxt_clr = 1'b0;   nxt_stp = 1'b0;
    nxt_hold = hold_ff; nxt_pwr = pwr_ff; hw_stop = 1'b0;
    if (cmd_wr) begin
      nxt_prog = 1'b0;
      unique case (cfg_wdata)
        `TPS_CMD_SCAN: begin
          if (st_ff != tps_pkg::ST_SCAN && st_ff != tps_pkg::ST_PRE) begin
            nxt_st  = tps_pkg::ST_PRE;
            nxt_cnt = lines_ff;
            nxt_fwd = 1'b1;
            nxt_clr = 1'b1;
          end
        end
        `TPS_CMD_FWD, `TPS_CMD_PFWD: begin
          nxt_st   = tps_pkg::ST_FEED;
          nxt_fwd  = 1'b1;
          nxt_prog = (cfg_wdata == `TPS_CMD_PFWD);
          nxt_cnt  = lines_ff;
        end
        `TPS_CMD_REV, `TPS_CMD_PREV: begin
          nxt_st   = tps_pkg::ST_FEED;
          nxt_fwd  = 1'b0;
          nxt_prog = (cfg_wdata == `TPS_CMD_PREV);
          nxt_cnt  = lines_ff;
        end
        default: nxt_st = tps_pkg::ST_IDLE;
      endcase
    end else begin
      unique case (st_ff)
        tps_pkg::ST_IDLE: ;
        tps_pkg::ST_PRE: begin
          if (cnt_ff == 16'h0000) begin
            nxt_st = tps_pkg::ST_SCAN;
          end else if (step_tick) begin
            nxt_stp = 1'b1;
            nxt_cnt = cnt_ff - 16'h0001;
          end
        end
        tps_pkg::ST_SCAN: begin
          if (sense1_trip || (sense2_trip && extra_steps == 8'h00)) begin
            nxt_st  = tps_pkg::ST_IDLE;
            hw_stop = 1'b1;
          end else if (sense2_trip) begin
            nxt_st  = tps_pkg::ST_TRAIL;
            nxt_cnt = {8'h00, extra_steps};
          end else if (step_tick && !buf_full) begin
            nxt_stp = 1'b1;
          end
        end
        tps_pkg::ST_FEED: begin
          if (sense1_trip || (sense2_trip && (!fwd_ff || extra_steps == 8'h00))) begin
            nxt_st  = tps_pkg::ST_IDLE;
            hw_stop = 1'b1;
          end else if (sense2_trip) begin
            nxt_st  = tps_pkg::ST_TRAIL;
            nxt_cnt = {8'h00, extra_steps};
          end else if (step_tick) begin
            nxt_stp = 1'b1;
            if (prog_ff) begin
              nxt_cnt = cnt_ff - 16'h0001;
              if (cnt_ff <= 16'h0001) begin
                nxt_st  = tps_pkg::ST_IDLE;
                hw_stop = 1'b1;
              end
            end
          end
        end
        tps_pkg::ST_TRAIL: begin
          if (step_tick) begin
            nxt_stp = 1'b1;
            nxt_cnt = cnt_ff - 16'h0001;
            if (cnt_ff <= 16'h0001) begin
              nxt_st  = tps_pkg::ST_IDLE;
              hw_stop = 1'b1;
            end
          end
        end
        default: begin
          nxt_st  = tps_pkg::ST_IDLE;
          hw_stop = 1'b1;
        end
      endcase
    end
    if (!paused) begin
      nxt_hold = 8'h00;
      nxt_pwr  = (nxt_st != tps_pkg::ST_IDLE);
    end else if (ms_tick) begin
      if (hold_ff >= hold_timeout) begin
        nxt_pwr = 1'b0;
      end else begin
        nxt_hold = hold_ff + 8'h01;
      end
    end
  end

  // Sequencer flops
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_ff <= tps_pkg::ST_IDLE; fwd_ff <= 1'b1; prog_ff <= 1'b0;
      cnt_ff <= 16'h0000; clr_ff <= 1'b0; stp_ff <= 1'b0;
      hold_ff <= 8'h00;   pwr_ff <= 1'b0;
    end else begin
      st_ff <= nxt_st;    fwd_ff <= nxt_fwd; prog_ff <= nxt_prog;
      cnt_ff <= nxt_cnt;  clr_ff <= nxt_clr; stp_ff <= nxt_stp;
      hold_ff <= nxt_hold; pwr_ff <= nxt_pwr;
    end
  end

  assign buf_clear   = clr_ff;
  assign step_pulse  = stp_ff;
  assign step_fwd    = fwd_ff;
  assign motor_power = pwr_ff;
  assign scanning    = (st_ff == tps_pkg::ST_PRE) || (st_ff == tps_pkg::ST_SCAN);

  // ==========================================================
  // Output byte formatter and line length
  logic        ov_ff,  nxt_ov;    // Byte valid
  logic [7:0]  ob_ff,  nxt_ob;    // Byte
  logic        pd_ff,  nxt_pd;    // Second byte pending
  logic [7:0]  pb_ff,  nxt_pb;    // Pending byte
  logic [19:0] bpl_ff, nxt_bpl;   // Bytes per line
  logic [13:0] quo;               // Pixels after divider
  logic [19:0] qc;                // Times colour factor
  logic [19:0] qcb;               // Times bits per pixel

  assign quo = data_pixels / ((hdpi_div == 4'h0) ? 14'h0001 : {10'h000, hdpi_div});
  assign qc  = {6'h00, quo} * (color_pixel_rate ? 20'h00003 : 20'h00001);
  assign qcb = qc << bits_code;

  // Byte sequencing
  always_comb begin
    nxt_ov = 1'b0;  nxt_ob = ob_ff;  nxt_pd = 1'b0;  nxt_pb = pb_ff;
    nxt_bpl = mode16 ? {qc[18:0], 1'b0} : {3'h0, qcb[19:4], 1'b0};
    if (pd_ff) begin
      nxt_ov = 1'b1;
      nxt_ob = pb_ff;
    end else if (line_end) begin
      // status word, fill in low byte
      nxt_ov = 1'b1;
      nxt_ob = 8'h00;
      nxt_pd = 1'b1;
      nxt_pb = buf_fill;
    end else if (pix_valid) begin
      nxt_ov = 1'b1;
      // two bytes per pixel, high first
      if (mode16) begin
        nxt_ob = pix_data[15:8];
        nxt_pd = 1'b1;
        nxt_pb = pix_data[7:0];
      end else begin
        nxt_ob = pix_data[7:0];
      end
    end
  end

  // Formatter flops
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ov_ff <= 1'b0; ob_ff <= 8'h00; pd_ff <= 1'b0; pb_ff <= 8'h00; bpl_ff <= 20'h00000;
    end else begin
      ov_ff <= nxt_ov; ob_ff <= nxt_ob; pd_ff <= nxt_pd; pb_ff <= nxt_pb; bpl_ff <= nxt_bpl;
    end
  end

  assign out_valid      = ov_ff;
  assign out_byte       = ob_ff;
  assign bytes_per_line = bpl_ff;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence s_scan_start;
    cmd_wr && cfg_wdata == `TPS_CMD_SCAN && st_ff == tps_pkg::ST_IDLE;
  endsequence

  a_gamma_wrap: assert property (word_done && is_gamma && addr_ff == 14'h0FFD |=> addr_ff == 14'h0000)
    else $error("gamma address did not wrap");
  a_coef_wrap: assert property (word_done && !is_gamma && addr_ff == 14'h3FFF |=> addr_ff == 14'h0000)
    else $error("coefficient address did not wrap");
  a_addr_step: assert property (word_done && !cfg_wr && addr_ff != last_addr |=> addr_ff == $past(addr_ff) + 14'h0001)
    else $error("address did not advance");
  a_gamma_nibble: assert property (gam_hi_ff |-> cfg_rvalid && cfg_rdata[7:4] == 4'h0)
    else $error("gamma high nibble not zero");
  a_clear_start: assert property (s_scan_start |=> buf_clear && st_ff == tps_pkg::ST_PRE)
    else $error("buffer not cleared at scan start");
  a_idle_stop: assert property (cmd_wr && cfg_wdata == `TPS_CMD_IDLE |=> st_ff == tps_pkg::ST_IDLE && !scanning)
    else $error("idle command did not stop");
  a_full_pause: assert property (paused && !cmd_wr |=> !step_pulse)
    else $error("step while buffer full");
  a_status_word: assert property (line_end && !pd_ff |=> out_valid && out_byte == 8'h00
                                  ##1 out_valid && out_byte == $past(buf_fill, 2))
    else $error("status word wrong");
  a_pix_pair: assert property (mode16 && pix_valid && !pd_ff && !line_end |=> out_byte == $past(pix_data[15:8])
                               ##1 out_byte == $past(pix_data[7:0], 2))
    else $error("sixteen bit pair wrong");
  a_rev_noextra: assert property (st_ff == tps_pkg::ST_FEED && !fwd_ff && sense2_trip && !cmd_wr
                                  |=> st_ff == tps_pkg::ST_IDLE)
    else $error("reverse feed did not stop");

endmodule

// file: testbench/table_port_and_scan_command_tb.sv
`timescale 1ns/100ps
module table_port_and_scan_command_tb;
  logic sys_clk, rst, cfg_wr, cfg_rd, cfg_rvalid, tbl_req, tbl_we, tbl_ack, buf_rd, buf_full, buf_clear, mode16;
  logic pix_valid, line_end, out_valid, color_pixel_rate, sense1_trip, sense2_trip, step_pulse, step_fwd;
  logic motor_power, scanning;
  logic [6:0]  cfg_addr;
  logic [7:0]  cfg_wdata, cfg_rdata, buf_rdata, buf_fill, out_byte, extra_steps, hold_timeout, hi, lo;
  logic [1:0]  tbl_target, tbl_color, bits_code;
  logic [13:0] tbl_addr, data_pixels, st;
  logic [15:0] tbl_wdata, tbl_rdata, pix_data, scan_stepsize, lfsr_q, words [3];
  logic [3:0]  hdpi_div;
  logic [19:0] bytes_per_line;
  int errors, samples_checked, clears, steps;
  tps_top #(.HOLD_TICK_CYC(4)) tps_top_i (.*);
  tps_mem_model tps_mem_model_i (.*);
  // ==========
  // Clock, pulse counters, helpers
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    if (buf_clear === 1'b1) clears++;
    if (step_pulse === 1'b1) steps++;
  end
  function logic [15:0] lfsr16();
    lfsr_q = {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
    return lfsr_q;
  endfunction
  function logic [19:0] bpl(input logic [13:0] p, input logic [3:0] d, input logic c, input logic [1:0] b,
                            input logic m);
    return 20'(2 * (((p / ((d == 4'h0) ? 1 : d)) * (c ? 3 : 1) * (m ? 16 : (1 << b))) / 16));
  endfunction
  task automatic chk(input string what, input logic [19:0] exp, input logic [19:0] got);
    samples_checked++;
    if (got !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      errors++;
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    {cfg_addr, cfg_wdata, cfg_wr} = {a, d, 1'b1};
    @(negedge sys_clk);
    cfg_wr = 1'b0;
  endtask
  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    @(negedge sys_clk);
    {cfg_addr, cfg_rd} = {a, 1'b1};
    @(negedge sys_clk);
    cfg_rd = 1'b0;
    if (cfg_rvalid !== 1'b1) @(negedge sys_clk);
    chk("cfg_rvalid", 20'h1, cfg_rvalid);
    d = cfg_rdata;
  endtask
  task automatic idle_wait();
    repeat (2) @(negedge sys_clk);
    for (int i = 0; i < 50 && tbl_req !== 1'b0; i++) @(negedge sys_clk);
    chk("tbl_req", 20'h0, tbl_req);
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge sys_clk);
    errors++;
    close_out();
  end
  // ==========
  // Tests
  initial begin
    lfsr_q = 16'h001D;
    {rst, cfg_wr, cfg_rd, cfg_addr, cfg_wdata, buf_rdata, buf_fill, buf_full, mode16} = {1'b1, 35'h0};
    {pix_valid, line_end, pix_data, color_pixel_rate, sense1_trip, sense2_trip} = 21'h0;
    {data_pixels, hdpi_div, bits_code, extra_steps, hold_timeout, scan_stepsize} = {36'h0, 16'hFFFF};
    repeat (2) @(negedge sys_clk);
    rst = 1'b0;
    rd(7'h49, hi);
    chk("feed step lo", 20'h10, hi);
    rd(7'h7F, hi);
    chk("unmapped", 20'h0, hi);
    for (int t = 0; t < 3; t++) begin
      st = (t == 2) ? 14'h0FFC : 14'h3FFE;
      wr(7'h03, {4'h0, 2'(t), 2'(t)});
      for (int pass = 0; pass < 2; pass++) begin
        wr(7'h04, {1'b0, 1'(pass), st[13:8]});
        wr(7'h05, st[7:0]);
        idle_wait();
        for (int w = 0; w < 3; w++) begin
          if (pass == 0) begin
            words[w] = lfsr16();
            wr(7'h06, words[w][15:8]);
            wr(7'h06, words[w][7:0]);
          end else begin
            rd(7'h06, hi);
            rd(7'h06, lo);
            chk("table word", (t == 2) ? {8'h0, words[w][11:0]} : {4'h0, words[w]}, {hi, lo});
          end
          idle_wait();
        end
      end
      chk("select out", 20'(t * 5), {tbl_color, tbl_target});
    end
    $display("test table port done");
    wr(7'h4A, 8'h00);
    wr(7'h4B, 8'h02);
    {clears, steps} = 64'h0;
    wr(7'h07, 8'h08);
    repeat (60) @(negedge sys_clk);
    chk("scanning", 20'h1, scanning);
    chk("pre steps", 20'h2, 20'(steps));
    rd(7'h03, hi);
    chk("select in scan", 20'h0A, hi);
    wr(7'h07, 8'h00);
    repeat (2) @(negedge sys_clk);
    chk("scan stop", 20'h0, scanning);
    chk("buffer clears", 20'h1, 20'(clears));
    $display("test scan done");
    wr(7'h07, 8'h02);
    repeat (40) @(negedge sys_clk);
    chk("reverse dir", 20'h0, step_fwd);
    sense1_trip = 1'b1;
    @(negedge sys_clk);
    sense1_trip = 1'b0;
    rd(7'h07, hi);
    chk("sensor stop", 20'h0, hi);
    steps = 0;
    wr(7'h07, 8'h05);
    repeat (80) @(negedge sys_clk);
    chk("prog steps", 20'h2, 20'(steps));
    chk("prog dir", 20'h1, step_fwd);
    extra_steps = 8'h02;
    wr(7'h07, 8'h01);
    repeat (20) @(negedge sys_clk);
    sense2_trip = 1'b1;
    @(negedge sys_clk);
    {sense2_trip, steps} = 33'h0;
    repeat (80) @(negedge sys_clk);
    chk("extra steps", 20'h2, 20'(steps));
    rd(7'h07, hi);
    chk("trail stop", 20'h0, hi);
    $display("test feed done");
    for (int i = 0; i < 8; i++) begin
      {data_pixels, hdpi_div, color_pixel_rate, bits_code, mode16} = 22'({lfsr16(), lfsr16()});
      repeat (2) @(negedge sys_clk);
      chk("line len", bpl(data_pixels, hdpi_div, color_pixel_rate, bits_code, mode16), bytes_per_line);
    end
    $display("test line length done");
    for (int i = 0; i < 4; i++) begin
      {mode16, pix_data, buf_fill, pix_valid} = {25'({lfsr16(), lfsr16()}), ~i[0]};
      line_end = i[0];
      @(negedge sys_clk);
      {pix_valid, line_end} = 2'b00;
      chk("byte 1", {1'b1, i[0] ? 8'h00 : (mode16 ? pix_data[15:8] : pix_data[7:0])}, {out_valid, out_byte});
      @(negedge sys_clk);
      chk("byte 2", i[0] ? {1'b1, buf_fill} : {mode16, pix_data[7:0]}, {out_valid, out_byte});
    end
    buf_rdata = 8'(lfsr16());
    rd(7'h00, hi);
    chk("pixel", {1'b1, buf_rdata}, {buf_rd, hi});
    rd(7'h01, lo);
    chk("fill reg", buf_fill, lo);
    {buf_full, scan_stepsize, hold_timeout, steps} = {1'b1, 16'h0004, 8'h02, 32'h0};
    wr(7'h07, 8'h08);
    repeat (80) @(negedge sys_clk);
    chk("paused steps", 20'h2, 20'(steps));
    chk("hold power", 20'h0, motor_power);
    buf_full = 1'b0;
    repeat (20) @(negedge sys_clk);
    chk("resumed", 20'h3, {motor_power, steps > 2});
    wr(7'h07, 8'h00);
    $display("test buffer done");
    close_out();
  end
endmodule

// file: testbench/tps_mem_model.sv
`timescale 1ns/100ps
// ==========
// Table memory partner, answers promptly or after up to 3 cycles
module tps_mem_model (
  // Clock
  input  wire logic        sys_clk,
  // Request
  input  wire logic        tbl_req,
  input  wire logic        tbl_we,
  input  wire logic [1:0]  tbl_target,
  input  wire logic [1:0]  tbl_color,
  input  wire logic [13:0] tbl_addr,
  input  wire logic [15:0] tbl_wdata,
  // Answer
  output logic             tbl_ack,
  output logic [15:0]      tbl_rdata
);
  logic [15:0] mem [int];  // Words by target, colour, address
  logic [13:0] wa;         // Write lands one word behind
  int          wait_cnt;   // Cycles waited on this request
  initial begin
    tbl_ack = 1'b0;
    tbl_rdata = 16'hA5A5;
    wait_cnt = 0;
  end
  // step back over the wrap point
  always_comb wa = (tbl_addr != 14'h0000) ? tbl_addr - 14'h0001 : ((tbl_target == 2'b10) ? 14'h0FFD : 14'h3FFF);
  // Answer one pulse; data toggles unless answering a read
  always @(posedge sys_clk) begin
    tbl_ack <= 1'b0;
    tbl_rdata <= ~tbl_rdata;
    if (tbl_req === 1'b1 && !tbl_ack) begin
      if (wait_cnt >= int'(tbl_addr[1:0])) begin
        tbl_ack <= 1'b1;
        wait_cnt <= 0;
        if (tbl_we) mem[{tbl_target, tbl_color, wa}] = tbl_wdata;
        else tbl_rdata <= mem.exists({tbl_target, tbl_color, tbl_addr}) ? mem[{tbl_target, tbl_color, tbl_addr}] : 16'h0000;
      end else wait_cnt <= wait_cnt + 1;
    end
  end
endmodule
